// File: src/spi_port_device.sv
// What this block does
// R1 - slave shifts only while select is low
// R2 - phase 1: master may hold select low
// R3 - phase 0: select framed around each byte
// R4 - slave reads select pin on rate bit
// R5 - done flag set per byte, cleared
// R6 - collision flag on busy data write
// R7 - bit 5 hands pins to serial port
// R8 - bit 4 master drives clock pin
// R9 - bit 3 sets clock idle level
// R10 - bit 2 selects launch edge
// R11 - bits 1:0 pick master bit rate
// R12 - master data write starts eight clocks
// R13 - master shifts both ways, latches, flags
// R14 - master selects slaves with port pin
// R15 - slave write loads byte, shifts per clock
// R16 - slave latch at byte end per phase
// R17 - both sides share polarity and phase
// R18 - data resets zero, write tx, read rx
// R19 - eight bits, msb first, full duplex
// R20 - power-of-two rates, fastest at zero
`timescale 1ns/10ps
module spi_port_device
(
  input  logic       mclk,
  input  logic       reset,
  input  logic [7:0] addr,
  input  logic [7:0] wrData,
  input  logic       wrStb,
  input  logic       rdStb,
  output logic [7:0] rdData,
  output logic       pinsToTwoWire,
  spi_link_if.device link
);

  logic [7:0]                  spiData;
  logic [7:0]                  txHold;
  logic [7:0]                  txShift;
  logic [7:0]                  rxShift;
  logic                        xferDoneFlag;
  logic                        writeCollisionFlag;
  logic                        serialPortSelect;
  logic                        masterSelect;
  logic                        clockIdleLevel;
  logic                        clockPhaseSelect;
  logic                        rateSelHi;
  logic                        rateSelLo;
  spi_port_pkg::master_state_t mState;
  logic [3:0]                  edgeCnt;
  logic [3:0]                  bitCnt;
  logic                        sclkReg;
  logic                        mosiReg;
  logic                        misoReg;
  logic                        prevSclk;
  logic                        prevSs;
  logic                        byteDone;
  logic                        tick;
  logic                        wrDataHit;
  logic                        wrCtrlHit;
  logic                        rdDataHit;
  logic                        masterMode;
  logic                        slaveMode;
  logic                        busy;
  logic                        collide;
  logic                        sclkEdge;
  logic                        leadingEdge;
  logic                        ssFall;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  assign wrDataHit  = wrStb && addr == spi_port_pkg::SPI_DATA_ADDR;
  assign wrCtrlHit  = wrStb && addr == spi_port_pkg::SPI_CONTROL_ADDR;
  assign rdDataHit  = rdStb && addr == spi_port_pkg::SPI_DATA_ADDR;
  assign masterMode = serialPortSelect && masterSelect; // [R7] [R8]
  assign slaveMode  = serialPortSelect && !masterSelect;
  assign busy       = masterMode ? (mState != spi_port_pkg::M_IDLE)
                                 : (slaveMode && bitCnt != 4'h0);
  assign collide    = wrDataHit && busy; // [R6]
  // pins are synchronous to mclk, so plain compare against last level
  assign sclkEdge    = link.sclk != prevSclk;
  assign leadingEdge = link.sclk != clockIdleLevel; // [R9]
  assign ssFall      = prevSs && !link.ssN;

  spi_rate_div u_rate_div
  (
    .mclk    (mclk),
    .reset   (reset),
    .run     (mState == spi_port_pkg::M_RUN),
    .rateSel ({rateSelHi, rateSelLo}), // [R11] [R20]
    .tick    (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // control register
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      serialPortSelect <= spi_port_pkg::SPI_CONTROL_RESET[spi_port_pkg::PORT_SELECT_BIT];
      masterSelect     <= spi_port_pkg::SPI_CONTROL_RESET[spi_port_pkg::MASTER_BIT];
      clockIdleLevel   <= spi_port_pkg::SPI_CONTROL_RESET[spi_port_pkg::IDLE_LEVEL_BIT];
      clockPhaseSelect <= spi_port_pkg::SPI_CONTROL_RESET[spi_port_pkg::PHASE_BIT];
      rateSelHi        <= spi_port_pkg::SPI_CONTROL_RESET[spi_port_pkg::RATE_HI_BIT];
      rateSelLo        <= spi_port_pkg::SPI_CONTROL_RESET[spi_port_pkg::RATE_LO_BIT];
    end
    else if (wrCtrlHit)
    begin
      serialPortSelect <= wrData[spi_port_pkg::PORT_SELECT_BIT];
      masterSelect     <= wrData[spi_port_pkg::MASTER_BIT];
      clockIdleLevel   <= wrData[spi_port_pkg::IDLE_LEVEL_BIT];
      clockPhaseSelect <= wrData[spi_port_pkg::PHASE_BIT];
      rateSelHi        <= wrData[spi_port_pkg::RATE_HI_BIT];
      rateSelLo        <= wrData[spi_port_pkg::RATE_LO_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags: a hardware set wins over a clear in the same cycle
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      xferDoneFlag <= spi_port_pkg::SPI_CONTROL_RESET[spi_port_pkg::XFER_DONE_BIT];
    end
    else if (byteDone)
    begin
      xferDoneFlag <= 1'b1; // [R5]
    end
    else if (rdDataHit)
    begin
      xferDoneFlag <= 1'b0; // [R5]
    end
    else if (wrCtrlHit)
    begin
      xferDoneFlag <= wrData[spi_port_pkg::XFER_DONE_BIT]; // [R5]
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      writeCollisionFlag <= spi_port_pkg::SPI_CONTROL_RESET[spi_port_pkg::WRITE_COLL_BIT];
    end
    else if (collide)
    begin
      writeCollisionFlag <= 1'b1; // [R6]
    end
    else if (wrCtrlHit)
    begin
      writeCollisionFlag <= wrData[spi_port_pkg::WRITE_COLL_BIT]; // [R6]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data register: a colliding write is dropped so the byte in flight survives
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      txHold <= spi_port_pkg::SPI_DATA_RESET;
    end
    else if (wrDataHit && !busy)
    begin
      txHold <= wrData; // [R15] [R18]
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      spiData <= spi_port_pkg::SPI_DATA_RESET; // [R18]
    end
    else if (byteDone)
    begin
      spiData <= rxShift; // [R13] [R16]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port, data valid only in the cycle after the strobe
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      rdData <= spi_port_pkg::READ_IDLE;
    end
    else if (rdStb && addr == spi_port_pkg::SPI_DATA_ADDR)
    begin
      rdData <= spiData; // [R18]
    end
    else if (rdStb && addr == spi_port_pkg::SPI_CONTROL_ADDR)
    begin
      rdData <= {xferDoneFlag, writeCollisionFlag, serialPortSelect, masterSelect,
                 clockIdleLevel, clockPhaseSelect, rateSelHi,
                 slaveMode ? link.ssN : rateSelLo}; // [R4]
    end
    else
    begin
      rdData <= spi_port_pkg::READ_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shift engine for both roles
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      mState   <= spi_port_pkg::M_IDLE;
      edgeCnt  <= 4'h0;
      bitCnt   <= 4'h0;
      txShift  <= 8'h00;
      rxShift  <= 8'h00;
      mosiReg  <= 1'b0;
      misoReg  <= 1'b0;
      byteDone <= 1'b0;
    end
    else
    begin
      byteDone <= 1'b0;
      if (!serialPortSelect)
      begin
        mState <= spi_port_pkg::M_IDLE;
        bitCnt <= 4'h0;
      end
      else if (masterSelect)
      begin
        // select pin plays no part here
        bitCnt <= 4'h0; // [R1]
        case (mState)
          spi_port_pkg::M_IDLE:
          begin
            if (wrDataHit)
            begin
              mState  <= spi_port_pkg::M_RUN; // [R12]
              edgeCnt <= 4'h0;
              if (!clockPhaseSelect)
              begin
                mosiReg <= wrData[7]; // [R10] [R19]
                txShift <= {wrData[6:0], 1'b0};
              end
              else
              begin
                txShift <= wrData;
              end
            end
          end
          spi_port_pkg::M_RUN:
          begin
            if (tick)
            begin
              edgeCnt <= edgeCnt + 4'h1;
              if (edgeCnt[0] == clockPhaseSelect)
              begin
                rxShift <= {rxShift[6:0], link.miso}; // [R13] [R10]
              end
              else if (clockPhaseSelect || edgeCnt != spi_port_pkg::LAST_EDGE)
              begin
                mosiReg <= txShift[7]; // [R13] [R19]
                txShift <= {txShift[6:0], 1'b0};
              end
              if (edgeCnt == spi_port_pkg::LAST_EDGE)
              begin
                mState <= spi_port_pkg::M_DONE; // [R12]
              end
            end
          end
          spi_port_pkg::M_DONE:
          begin
            mState   <= spi_port_pkg::M_IDLE;
            byteDone <= 1'b1; // [R13]
          end
          default:
          begin
            mState <= spi_port_pkg::M_IDLE;
          end
        endcase
      end
      else
      begin
        mState <= spi_port_pkg::M_IDLE;
        if (link.ssN)
        begin
          // phase 0 byte ends when select rises
          if (!clockPhaseSelect && bitCnt == spi_port_pkg::BITS_PER_BYTE)
          begin
            byteDone <= 1'b1; // [R16]
          end
          bitCnt <= 4'h0; // [R1]
        end
        else if (ssFall && !clockPhaseSelect)
        begin
          misoReg <= txHold[7]; // [R15]
          txShift <= {txHold[6:0], 1'b0};
        end
        else if (sclkEdge)
        begin
          if (leadingEdge != clockPhaseSelect)
          begin
            rxShift <= {rxShift[6:0], link.mosi}; // [R15] [R19]
            if (clockPhaseSelect && bitCnt == spi_port_pkg::LAST_BIT)
            begin
              bitCnt   <= 4'h0;
              byteDone <= 1'b1; // [R16]
            end
            else
            begin
              bitCnt <= bitCnt + 4'h1;
            end
          end
          else if (clockPhaseSelect && bitCnt == 4'h0)
          begin
            misoReg <= txHold[7]; // [R15]
            txShift <= {txHold[6:0], 1'b0};
          end
          else if (bitCnt != spi_port_pkg::BITS_PER_BYTE)
          begin
            misoReg <= txShift[7]; // [R15]
            txShift <= {txShift[6:0], 1'b0};
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers, all registered
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      sclkReg <= 1'b0;
    end
    else if (mState != spi_port_pkg::M_RUN)
    begin
      sclkReg <= clockIdleLevel; // [R9]
    end
    else if (tick)
    begin
      sclkReg <= ~sclkReg;
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      prevSclk       <= 1'b0;
      prevSs         <= 1'b1;
      link.devSclkOe <= 1'b0;
      link.devMosiOe <= 1'b0;
      link.devMisoOe <= 1'b0;
      pinsToTwoWire  <= 1'b1;
    end
    else
    begin
      prevSclk       <= link.sclk;
      prevSs         <= link.ssN;
      link.devSclkOe <= masterMode; // [R8]
      link.devMosiOe <= masterMode;
      // slave only drives its output while selected, for multi-slave buses
      link.devMisoOe <= slaveMode && !link.ssN; // [R1]
      pinsToTwoWire  <= !serialPortSelect; // [R7]
    end
  end

  assign link.devSclkO = sclkReg;
  assign link.devMosiO = mosiReg;
  assign link.devMisoO = misoReg;

endmodule : spi_port_device

// File: src/spi_port_pkg.sv
package spi_port_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [7:0] SPI_DATA_ADDR    = 8'hf7;
  localparam logic [7:0] SPI_CONTROL_ADDR = 8'hf8;
  localparam logic [7:0] SPI_DATA_RESET    = 8'h00;
  localparam logic [7:0] SPI_CONTROL_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE         = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // control field positions
  localparam int XFER_DONE_BIT   = 7;
  localparam int WRITE_COLL_BIT  = 6;
  localparam int PORT_SELECT_BIT = 5;
  localparam int MASTER_BIT      = 4;
  localparam int IDLE_LEVEL_BIT  = 3;
  localparam int PHASE_BIT       = 2;
  localparam int RATE_HI_BIT     = 1;
  localparam int RATE_LO_BIT     = 0;

  ////////////////////////////////////////////////////////////////////////////
  // byte framing counts
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_BIT      = 4'h7;
  localparam logic [3:0] LAST_EDGE     = 4'hf;
  localparam int         DIV_CNT_W     = 4;

  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_RUN  = 2'b01,
    M_DONE = 2'b10
  } master_state_t;

  typedef enum logic [1:0] {
    F_IDLE = 2'b00,
    F_LEAD = 2'b01,
    F_RUN  = 2'b10,
    F_TAIL = 2'b11
  } far_state_t;

endpackage : spi_port_pkg

// File: src/spi_link_if.sv
`timescale 1ns/10ps
interface spi_link_if;
  logic devSclkO;
  logic devSclkOe;
  logic devMosiO;
  logic devMosiOe;
  logic devMisoO;
  logic devMisoOe;
  logic farSclkO;
  logic farSclkOe;
  logic farMosiO;
  logic farMosiOe;
  logic farMisoO;
  logic farMisoOe;
  logic farSsN;
  logic farSsOe;
  logic sclk;
  logic mosi;
  logic miso;
  logic ssN;

  // resolved wire levels; undriven lines fall to a pull level
  assign sclk = devSclkOe ? devSclkO : (farSclkOe ? farSclkO : 1'b0);
  assign mosi = devMosiOe ? devMosiO : (farMosiOe ? farMosiO : 1'b1);
  assign miso = devMisoOe ? devMisoO : (farMisoOe ? farMisoO : 1'b1);
  assign ssN  = farSsOe ? farSsN : 1'b1;

  modport device (
    input  sclk, mosi, miso, ssN,
    output devSclkO, devSclkOe, devMosiO, devMosiOe, devMisoO, devMisoOe
  );

  modport far (
    input  sclk, mosi, miso,
    output farSclkO, farSclkOe, farMosiO, farMosiOe, farMisoO, farMisoOe,
    output farSsN, farSsOe
  );
endinterface : spi_link_if

// File: src/spi_rate_div.sv
`timescale 1ns/10ps
module spi_rate_div
#(
  parameter int CNT_W = spi_port_pkg::DIV_CNT_W
)
(
  input  logic       mclk,
  input  logic       reset,
  input  logic       run,
  input  logic [1:0] rateSel,
  output logic       tick
);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] lastCount;

  // half period of 1, 2, 4 or 8 core clocks, fastest at select 0
  assign lastCount = (CNT_W'(1) << rateSel) - CNT_W'(1);

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      count <= '0;
    end
    else if (!run || count == lastCount)
    begin
      count <= '0;
    end
    else
    begin
      count <= count + CNT_W'(1);
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      tick <= 1'b0;
    end
    else
    begin
      tick <= run && count == lastCount;
    end
  end

endmodule : spi_rate_div

// File: src/spi_far_end.sv
`timescale 1ns/10ps
module spi_far_end
(
  input  logic       mclk,
  input  logic       reset,
  input  logic       isMaster,
  input  logic       clock_idle_level,
  input  logic       clock_phase_select,
  input  logic [1:0] rateSel,
  input  logic       start,
  input  logic [7:0] txByte,
  output logic [7:0] rxByte,
  output logic       done,
  output logic       busy,
  spi_link_if.far    link
);

  spi_port_pkg::far_state_t fState;
  logic [3:0]               edgeCnt;
  logic [3:0]               bitCnt;
  logic [7:0]               txShift;
  logic [7:0]               rxShift;
  logic [7:0]               txHold;
  logic                     sclkReg;
  logic                     outReg;
  logic                     prevSclk;
  logic                     tick;

  spi_rate_div u_rate_div
  (
    .mclk    (mclk),
    .reset   (reset),
    .run     (fState != spi_port_pkg::F_IDLE),
    .rateSel (rateSel),
    .tick    (tick)
  );

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      fState   <= spi_port_pkg::F_IDLE;
      edgeCnt  <= 4'h0;
      bitCnt   <= 4'h0;
      txShift  <= 8'h00;
      rxShift  <= 8'h00;
      txHold   <= 8'h00;
      rxByte   <= 8'h00;
      sclkReg  <= 1'b0;
      outReg   <= 1'b0;
      prevSclk <= 1'b0;
      done     <= 1'b0;
      busy     <= 1'b0;
      link.farSsN <= 1'b1;
    end
    else
    begin
      done     <= 1'b0;
      prevSclk <= link.sclk;
      if (isMaster)
      begin
        case (fState)
          spi_port_pkg::F_IDLE:
          begin
            sclkReg     <= clock_idle_level; // [R17]
            link.farSsN <= 1'b1;
            if (start)
            begin
              // select frames every byte, valid for either phase
              fState      <= spi_port_pkg::F_LEAD; // [R2] [R3]
              link.farSsN <= 1'b0;
              busy        <= 1'b1;
              edgeCnt     <= 4'h0;
              outReg      <= txByte[7];
              txShift     <= clock_phase_select ? txByte : {txByte[6:0], 1'b0};
            end
          end
          spi_port_pkg::F_LEAD:
          begin
            if (tick)
            begin
              fState <= spi_port_pkg::F_RUN;
            end
          end
          spi_port_pkg::F_RUN:
          begin
            if (tick)
            begin
              sclkReg <= ~sclkReg;
              edgeCnt <= edgeCnt + 4'h1;
              if (edgeCnt[0] == clock_phase_select)
              begin
                rxShift <= {rxShift[6:0], link.miso}; // [R19]
              end
              else if (clock_phase_select || edgeCnt != spi_port_pkg::LAST_EDGE)
              begin
                outReg  <= txShift[7];
                txShift <= {txShift[6:0], 1'b0};
              end
              if (edgeCnt == spi_port_pkg::LAST_EDGE)
              begin
                fState <= spi_port_pkg::F_TAIL;
              end
            end
          end
          spi_port_pkg::F_TAIL:
          begin
            if (tick)
            begin
              fState      <= spi_port_pkg::F_IDLE;
              link.farSsN <= 1'b1; // [R3]
              rxByte      <= rxShift;
              done        <= 1'b1;
              busy        <= 1'b0;
            end
          end
          default:
          begin
            fState <= spi_port_pkg::F_IDLE;
          end
        endcase
      end
      else
      begin
        // slave role; it has no select input and shifts on every clock edge except the last edge of a phase 0 byte
        fState      <= spi_port_pkg::F_IDLE; // [R14]
        link.farSsN <= 1'b1;
        busy        <= bitCnt != 4'h0;
        if (start)
        begin
          txHold <= txByte;
        end
        if (link.sclk != prevSclk)
        begin
          if ((link.sclk != clock_idle_level) != clock_phase_select)
          begin
            rxShift <= {rxShift[6:0], link.mosi}; // [R17] [R19]
            if (bitCnt == spi_port_pkg::LAST_BIT)
            begin
              bitCnt <= 4'h0;
              rxByte <= {rxShift[6:0], link.mosi};
              done   <= 1'b1;
            end
            else
            begin
              bitCnt <= bitCnt + 4'h1;
            end
          end
          else if (clock_phase_select && bitCnt == 4'h0)
          begin
            outReg  <= txHold[7];
            txShift <= {txHold[6:0], 1'b0};
          end
          else if (bitCnt != 4'h0)
          begin
            outReg  <= txShift[7];
            txShift <= {txShift[6:0], 1'b0};
          end
        end
        else if (!clock_phase_select && bitCnt == 4'h0)
        begin
          outReg  <= txHold[7];
          txShift <= {txHold[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      link.farSclkOe <= 1'b0;
      link.farMosiOe <= 1'b0;
      link.farMisoOe <= 1'b0;
      link.farSsOe   <= 1'b0;
    end
    else
    begin
      link.farSclkOe <= isMaster;
      link.farMosiOe <= isMaster;
      link.farMisoOe <= !isMaster;
      link.farSsOe   <= isMaster;
    end
  end

  assign link.farSclkO = sclkReg;
  assign link.farMosiO = outReg;
  assign link.farMisoO = outReg;

endmodule : spi_far_end

// File: test/spi_port_chk.sv
`timescale 1ns/10ps
module spi_port_chk
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic devSclkOe,
  input wire logic devMosiOe,
  input wire logic devMisoOe,
  input wire logic farSclkOe,
  input wire logic farMosiOe,
  input wire logic farMisoOe,
  input wire logic farSsN,
  input wire logic farSsOe,
  input wire logic sclk,
  input wire logic ssN
);
  logic [4:0] edgeCnt;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  ////////////////////////////////////////
  // edges seen while the far master selects
  always_ff @(posedge mclk or posedge reset)
    if (reset)
      edgeCnt <= 5'h00;
    else if (farSsN)
      edgeCnt <= 5'h00;
    else if ($changed(sclk))
      edgeCnt <= edgeCnt + 5'h01;

  property p_sclkOwner; !(devSclkOe && farSclkOe); endproperty
  a_sclkOwner: assert property (p_sclkOwner) else $error("clock driven twice");
  property p_mosiOwner; !(devMosiOe && farMosiOe); endproperty
  a_mosiOwner: assert property (p_mosiOwner) else $error("mosi driven twice");
  property p_misoOwner; !(devMisoOe && farMisoOe); endproperty
  a_misoOwner: assert property (p_misoOwner) else $error("miso driven twice");
  // one cycle of lag on the select path is allowed
  property p_selGate; devMisoOe |-> !$past(ssN) || !$past(ssN, 2); endproperty
  a_selGate: assert property (p_selGate) else $error("miso driven unselected");
  property p_masterPins; devSclkOe |-> devMosiOe && !devMisoOe; endproperty
  a_masterPins: assert property (p_masterPins) else $error("master pin mix");
  property p_farPins; farSsOe |-> farSclkOe && farMosiOe && !farMisoOe; endproperty
  a_farPins: assert property (p_farPins) else $error("far pin mix");
  property p_frame; $rose(farSsN) |-> edgeCnt == 5'h10; endproperty
  a_frame: assert property (p_frame) else $error("frame edge count");
  property p_idle; farSclkOe && $past(farSclkOe) && farSsN && $past(farSsN) |-> $stable(sclk);
  endproperty
  a_idle: assert property (p_idle) else $error("clock moved while idle");
endmodule : spi_port_chk

// File: test/spi_master_slave_port_tb.sv
`timescale 1ns/10ps
module spi_master_slave_port_tb;
  localparam logic [7:0] CA = spi_port_pkg::SPI_CONTROL_ADDR;
  localparam logic [7:0] DA = spi_port_pkg::SPI_DATA_ADDR;
  logic       mclk;
  logic       reset;
  logic [7:0] addr;
  logic [7:0] wrData;
  logic       wrStb;
  logic       rdStb;
  logic [7:0] rdData;
  logic       toTw;
  logic       isMaster;
  logic       clock_idle_level;
  logic       clock_phase_select;
  logic [1:0] rateSel;
  logic       start;
  logic [7:0] txByte;
  logic [7:0] rxByte;
  logic [7:0] v;
  logic [7:0] ctl;
  logic [7:0] dtx;
  int         err_count = 0;
  int         checks_done = 0;
  int         cycles = 0;

  spi_link_if lnk();
  spi_port_device i_spi_port_device (.mclk(mclk), .reset(reset), .addr(addr),
    .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
    .pinsToTwoWire(toTw), .link(lnk));
  spi_far_end i_spi_far_end (.mclk(mclk), .reset(reset), .isMaster(isMaster), .clock_idle_level(clock_idle_level),
    .clock_phase_select(clock_phase_select), .rateSel(rateSel), .start(start), .txByte(txByte), .rxByte(rxByte),
    .done(), .busy(), .link(lnk));
  spi_port_chk i_spi_port_chk (.mclk(mclk), .reset(reset), .devSclkOe(lnk.devSclkOe),
    .devMosiOe(lnk.devMosiOe), .devMisoOe(lnk.devMisoOe), .farSclkOe(lnk.farSclkOe),
    .farMosiOe(lnk.farMosiOe), .farMisoOe(lnk.farMisoOe), .farSsN(lnk.farSsN),
    .farSsOe(lnk.farSsOe), .sclk(lnk.sclk), .ssN(lnk.ssN));

  ////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr   <= a;
    wrData <= d;
    wrStb  <= 1'b1;
    @(posedge mclk);
    wrStb  <= 1'b0;
  endtask : wr

  // read data only stand in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    addr  <= a;
    rdStb <= 1'b1;
    @(posedge mclk);
    rdStb <= 1'b0;
    @(negedge mclk);
    v = rdData;
  endtask : rd

  task automatic farGo(input logic [7:0] b);
    @(posedge mclk);
    txByte <= b;
    start  <= 1'b1;
    @(posedge mclk);
    start  <= 1'b0;
  endtask : farGo

  // bounded poll; a timeout shows up in the caller's compare
  task automatic waitDone();
    v = 8'h00;
    for (int n = 0; n < 300 && v[7] !== 1'b1; n++)
      rd(CA);
  endtask : waitDone

  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      print_verdict();
    end
  end

  initial
  begin
    reset = 1'b1;
    addr = 8'h00;
    wrData = 8'h00;
    wrStb = 1'b0;
    rdStb = 1'b0;
    isMaster = 1'b0;
    clock_idle_level = 1'b0;
    clock_phase_select = 1'b0;
    rateSel = 2'b00;
    start = 1'b0;
    txByte = 8'h00;
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    rd(DA);
    chk(v, 8'h00);
    rd(8'h40);
    chk(v, spi_port_pkg::READ_IDLE);
    chk({7'h00, toTw}, 8'h01);
    // device master, far slave: every polarity and phase, rate selects 1 to 3
    for (int m = 0; m < 4; m++)
    begin
      // far slave sees each pin level a cycle late, so rate select 0 is too fast for it
      ctl = {4'h3, m[1:0], m[1], m[1] ? m[0] : 1'b1};
      dtx = 8'h96 ^ {4{m[1:0]}};
      clock_idle_level <= m[1];
      clock_phase_select <= m[0];
      rateSel <= m[1:0];
      wr(CA, ctl);
      farGo(~dtx);
      chk({7'h00, toTw}, 8'h00);
      wr(DA, dtx);
      wr(DA, 8'h00);
      waitDone();
      chk(v, ctl | 8'hc0);
      chk(rxByte, dtx);
      rd(DA);
      chk(v, ~dtx);
      rd(CA);
      chk(v, ctl | 8'h40);
      wr(CA, ctl);
      rd(CA);
      chk(v, ctl);
    end
    // device slave, far master
    for (int m = 0; m < 4; m++)
    begin
      ctl = {4'h2, m[1:0], 2'b00};
      dtx = 8'h3c ^ {4{m[1:0]}};
      isMaster <= 1'b0;
      clock_idle_level <= m[1];
      clock_phase_select <= m[0];
      rateSel <= 2'b01;
      wr(CA, ctl);
      rd(CA);
      chk(v, ctl | 8'h01);
      wr(DA, dtx);
      isMaster <= 1'b1;
      farGo(~dtx);
      waitDone();
      chk(v, ctl | 8'h81);
      chk(rxByte, dtx);
      rd(DA);
      chk(v, ~dtx);
    end
    print_verdict();
  end
endmodule : spi_master_slave_port_tb
